// ### design/pcs_startup.v
// Post-configuration startup sequencer with an APB register slave.
// Assumes all pins are synchronous to CLK_IN and that the startup clock
// sources toggle well below half the CLK_IN rate.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_startup_regs.vh"

module pcs_startup (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  input wire CONFIGURATION_CLOCK_IN,
  input wire USER_CLOCK_IN,
  input wire TEST_CLOCK_IN,
  input wire CODE_LOAD_IN,
  input wire [31:0] CODE_DATA_IN,
  input wire CLOCK_MANAGER_LOCK_IN,
  input wire IMPEDANCE_CONTROLLER_LOCK_IN,
  input wire [2:0] MODE_PIN_IN,
  input wire COMPLETION_PIN_IN,
  output reg COMPLETION_PIN_OUT,
  output reg COMPLETION_PIN_OE_N_OUT,
  output reg GLOBAL_WRITE_ENABLE_OUT,
  output reg BLOCK_MEMORY_ACCESS_OUT,
  output reg GLOBAL_IO_THREE_STATE_OUT,
  output reg IO_THREE_STATE_RELEASE_OUT,
  output reg PERSIST_SERIAL_PINS_OUT,
  output reg PERSIST_PARALLEL_PINS_OUT,
  output reg READBACK_BLOCK_OUT,
  output reg RECONFIG_BLOCK_OUT
);

  // Sequencer states, one-hot.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_FINISHED = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg [`PCS_CFG_WIDTH-1:0] config_reg;
  reg [31:0] user_design_code_reg;
  reg start_reg;
  reg global_write_enable_reg;
  reg global_write_enable_next;
  reg three_state_reg;
  reg three_state_next;
  reg done_active_reg;
  reg done_active_next;
  reg pipe_level_reg;
  reg completion_input_level;
  reg step_en;
  reg stall;
  reg [31:0] read_data;
  reg read_hit;

  wire cfg_rise;
  wire user_rise;
  wire test_rise;
  wire apb_access;
  wire apb_commit;
  wire running;

  // Configuration fields.
  wire [2:0] write_enable_phase = config_reg[`PCS_CFG_WE_LSB +: 3];
  wire [2:0] three_state_release_phase = config_reg[`PCS_CFG_TS_LSB +: 3];
  wire [2:0] completion_phase = config_reg[`PCS_CFG_DONE_LSB +: 3];
  wire [2:0] lock_wait_phase = config_reg[`PCS_CFG_LOCK_LSB +: 3];
  wire [2:0] match_wait_phase = config_reg[`PCS_CFG_MATCH_LSB +: 3];
  wire completion_pipeline_option = config_reg[`PCS_CFG_PIPE_BIT];
  wire completion_active_drive = config_reg[`PCS_CFG_DRIVE_BIT];
  wire persist_option = config_reg[`PCS_CFG_PERSIST_BIT];
  wire [1:0] security_level = config_reg[`PCS_CFG_SEC_LSB +: 2];
  wire [1:0] sequence_clock_select = config_reg[`PCS_CFG_CLK_LSB +: 2];

  // Edge detectors for the three possible startup clock sources.
  pcs_edge_detect u_cfg_edge (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(CONFIGURATION_CLOCK_IN),
    .rise_out(cfg_rise)
  );

  pcs_edge_detect u_user_edge (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(USER_CLOCK_IN),
    .rise_out(user_rise)
  );

  pcs_edge_detect u_test_edge (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(TEST_CLOCK_IN),
    .rise_out(test_rise)
  );

  // Picks the startup clock edge; an unused code falls back to the configuration clock.
  always @* begin
    case (sequence_clock_select)
      `PCS_CLK_USER: step_en = user_rise;
      `PCS_CLK_TEST: step_en = test_rise;
      default: step_en = cfg_rise;
    endcase
  end

  assign running = state_reg[1];

  // The completion level is the pin, or its copy taken on a startup clock edge.
  always @* begin
    if (completion_pipeline_option) begin
      completion_input_level = pipe_level_reg;
    end else begin
      completion_input_level = COMPLETION_PIN_IN;
    end
  end

  // Samples the completion pin once per startup clock edge for pipelining.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pipe_level_reg <= 1'b0;
    end else if (step_en) begin
      pipe_level_reg <= COMPLETION_PIN_IN;
    end
  end

  // Stalls the current phase while an enabled wait is not yet satisfied.
  always @* begin
    stall = 1'b0;
    if (lock_wait_phase != `PCS_NO_WAIT && lock_wait_phase == phase_reg &&
        !CLOCK_MANAGER_LOCK_IN) begin
      stall = 1'b1;
    end
    if (match_wait_phase != `PCS_NO_WAIT && match_wait_phase == phase_reg &&
        !IMPEDANCE_CONTROLLER_LOCK_IN) begin
      stall = 1'b1;
    end
    if (completion_pipeline_option && done_active_reg && !completion_input_level &&
        phase_reg == completion_phase) begin
      stall = 1'b1;
    end
  end

  // Phase sequencing: idle until started, one phase per enabled edge, then done.
  always @* begin
    state_next = state_reg;
    phase_next = phase_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_reg) begin
          state_next = ST_RUN;
          phase_next = 3'h0;
        end
      end
      ST_RUN: begin
        if (step_en && !stall) begin
          if (phase_reg == `PCS_LAST_PHASE) begin
            state_next = ST_FINISHED;
          end else begin
            phase_next = phase_reg + 3'h1;
          end
        end
      end
      ST_FINISHED: begin
        state_next = ST_FINISHED;
      end
      default: begin
        state_next = ST_IDLE;
        phase_next = 3'h0;
      end
    endcase
  end

  // Global outputs only ever move toward their final value while running.
  always @* begin
    global_write_enable_next = global_write_enable_reg;
    three_state_next = three_state_reg;
    done_active_next = done_active_reg;
    if (running) begin
      case (write_enable_phase)
        `PCS_PH_HOLD: global_write_enable_next = global_write_enable_reg;
        `PCS_PH_FOLLOW: begin
          if (completion_input_level) begin
            global_write_enable_next = 1'b1;
          end
        end
        default: begin
          if (phase_reg >= write_enable_phase) begin
            global_write_enable_next = 1'b1;
          end
        end
      endcase
      case (three_state_release_phase)
        `PCS_PH_HOLD: three_state_next = three_state_reg;
        `PCS_PH_FOLLOW: begin
          if (completion_input_level) begin
            three_state_next = 1'b0;
          end
        end
        default: begin
          if (phase_reg >= three_state_release_phase) begin
            three_state_next = 1'b0;
          end
        end
      endcase
      if (phase_reg >= completion_phase) begin
        done_active_next = 1'b1;
      end
    end
  end

  // Sequencer state, phase and global control flip-flops.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_IDLE;
      phase_reg <= 3'h0;
      global_write_enable_reg <= 1'b0;
      three_state_reg <= 1'b1;
      done_active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      global_write_enable_reg <= global_write_enable_next;
      three_state_reg <= three_state_next;
      done_active_reg <= done_active_next;
    end
  end

  // Registered copies of the global controls drive the device-wide nets.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      GLOBAL_WRITE_ENABLE_OUT <= 1'b0;
      BLOCK_MEMORY_ACCESS_OUT <= 1'b0;
      GLOBAL_IO_THREE_STATE_OUT <= 1'b1;
      IO_THREE_STATE_RELEASE_OUT <= 1'b0;
    end else begin
      GLOBAL_WRITE_ENABLE_OUT <= global_write_enable_next;
      BLOCK_MEMORY_ACCESS_OUT <= global_write_enable_next;
      GLOBAL_IO_THREE_STATE_OUT <= three_state_next;
      IO_THREE_STATE_RELEASE_OUT <= ~three_state_next;
    end
  end

  // Completion pin: held low until activation, then released or driven high.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      COMPLETION_PIN_OUT <= 1'b0;
      COMPLETION_PIN_OE_N_OUT <= 1'b0;
    end else if (!done_active_next) begin
      COMPLETION_PIN_OUT <= 1'b0;
      COMPLETION_PIN_OE_N_OUT <= 1'b0;
    end else if (completion_active_drive) begin
      COMPLETION_PIN_OUT <= 1'b1;
      COMPLETION_PIN_OE_N_OUT <= 1'b0;
    end else begin
      COMPLETION_PIN_OUT <= 1'b0;
      COMPLETION_PIN_OE_N_OUT <= 1'b1;
    end
  end

  // Configuration pins keep their role during configuration and, with persistence, after.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PERSIST_SERIAL_PINS_OUT <= 1'b0;
      PERSIST_PARALLEL_PINS_OUT <= 1'b0;
    end else begin
      PERSIST_SERIAL_PINS_OUT <= (!state_reg[2] || persist_option) &&
                                 (MODE_PIN_IN != `PCS_MODE_PARALLEL);
      PERSIST_PARALLEL_PINS_OUT <= (!state_reg[2] || persist_option) &&
                                   (MODE_PIN_IN == `PCS_MODE_PARALLEL);
    end
  end

  // Security blocks follow the configured level.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      READBACK_BLOCK_OUT <= 1'b0;
      RECONFIG_BLOCK_OUT <= 1'b0;
    end else begin
      READBACK_BLOCK_OUT <= (security_level != 2'h0);
      RECONFIG_BLOCK_OUT <= (security_level > `PCS_SEC_LEVEL1);
    end
  end

  // User design code is loaded from the configuration data stream.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      user_design_code_reg <= `PCS_USER_CODE_RESET;
    end else if (CODE_LOAD_IN) begin
      user_design_code_reg <= CODE_DATA_IN;
    end
  end

  // APB handshake: access phase is answered one cycle after it starts.
  assign apb_access = PSEL_IN & PENABLE_IN;
  assign apb_commit = apb_access & PREADY_OUT;

  // Read multiplexer and address decode.
  always @* begin
    read_data = 32'h00000000;
    read_hit = 1'b1;
    case (PADDR_IN)
      `PCS_OFF_CONFIG: read_data = {10'h000, config_reg};
      `PCS_OFF_CONTROL: read_data = 32'h00000000;
      `PCS_OFF_STATUS: read_data = {23'h000000, completion_input_level,
                                    done_active_reg, three_state_reg,
                                    global_write_enable_reg, state_reg[2],
                                    state_reg[1], phase_reg};
      `PCS_OFF_USER_CODE: read_data = user_design_code_reg;
      default: read_hit = 1'b0;
    endcase
  end

  // APB response flip-flops.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end else if (apb_access && !PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : read_data;
      PSLVERR_OUT <= ~read_hit | (PWRITE_IN && PADDR_IN == `PCS_OFF_STATUS) |
                     (PWRITE_IN && PADDR_IN == `PCS_OFF_USER_CODE);
    end else begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end
  end

  // Register writes take effect on the completing access edge.
  always @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      config_reg <= `PCS_CFG_RESET;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (apb_commit && PWRITE_IN) begin
        if (PADDR_IN == `PCS_OFF_CONFIG) begin
          config_reg <= PWDATA_IN[`PCS_CFG_WIDTH-1:0];
        end
        if (PADDR_IN == `PCS_OFF_CONTROL) begin
          start_reg <= PWDATA_IN[0];
        end
      end
    end
  end

endmodule // pcs_startup

`default_nettype wire

// ### pkg/pcs_startup_regs.vh
// Constants of the post-configuration startup sequencer: register offsets,
// field positions, reset values and encodings.
// Assumes inclusion by bare name from the design files under design/.
// Contract
// - Global write enable rises at a selectable phase 1 to 6, default 6.
// - Block memory reads and writes stay blocked until write enable rises.
// - Follow-completion setting raises write enable once completion level is high.
// - Hold setting leaves write enable at its present value.
// - I/O three-state released at a selectable phase 1 to 6, default 5.
// - Three-state release follows completion level, or holds its value.
// - Optional stall at phase 0 to 6 until clock manager locks; default none.
// - Optional stall at phase 0 to 6 until impedance locks; default none.
// - Completion signal activates at phase 1 to 6, default 4.
// - Pipelined completion waits for pin, then a startup clock edge.
// - Active drive option drives the completion pin high instead of open drain.
// - Persistence keeps configuration pins in their role after startup.
// - Mode pins pick persisted pins: serial set or parallel set.
// - Security level 1 blocks readback; level 2 also blocks reconfiguration.
// - A 32-bit user design code, loaded from configuration data, resets to all ones.
// - Startup clock: configuration clock, user clock or test-port clock.
`ifndef PCS_STARTUP_REGS_VH
`define PCS_STARTUP_REGS_VH

// APB byte offsets.
`define PCS_OFF_CONFIG 8'h00
`define PCS_OFF_CONTROL 8'h04
`define PCS_OFF_STATUS 8'h08
`define PCS_OFF_USER_CODE 8'h0C

// Configuration register fields.
`define PCS_CFG_WE_LSB 0
`define PCS_CFG_TS_LSB 3
`define PCS_CFG_DONE_LSB 6
`define PCS_CFG_LOCK_LSB 9
`define PCS_CFG_MATCH_LSB 12
`define PCS_CFG_PIPE_BIT 15
`define PCS_CFG_DRIVE_BIT 16
`define PCS_CFG_PERSIST_BIT 17
`define PCS_CFG_SEC_LSB 18
`define PCS_CFG_CLK_LSB 20
`define PCS_CFG_WIDTH 22

// Phase-field encodings.
`define PCS_PH_FOLLOW 3'h0
`define PCS_PH_HOLD 3'h7
`define PCS_NO_WAIT 3'h7
`define PCS_LAST_PHASE 3'h7

// Reset values.
`define PCS_CFG_RESET 22'h007F2E
`define PCS_USER_CODE_RESET 32'hFFFFFFFF

// Startup clock selections.
`define PCS_CLK_CONFIG 2'h0
`define PCS_CLK_USER 2'h1
`define PCS_CLK_TEST 2'h2

// Security levels.
`define PCS_SEC_LEVEL1 2'h1

// Mode pin code that selects the parallel configuration mode.
`define PCS_MODE_PARALLEL 3'h6

`endif

// ### design/pcs_edge_detect.v
// Rising-edge detector for one slow clock-like input sampled by CLK_IN.
// Assumes the input is synchronous to CLK_IN, so one sample stage suffices.
`timescale 1ns/1ps
`default_nettype none

module pcs_edge_detect (
  input wire clk_in,
  input wire rst_n_in,
  input wire level_in,
  output wire rise_out
);

  reg last_reg;

  // Holds the previous sample of the input level.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level_in;
    end
  end

  // One-cycle pulse when the level goes from low to high.
  assign rise_out = level_in & ~last_reg;

endmodule // pcs_edge_detect

`default_nettype wire

// ### sim/pcs_startup_monitor.sv
// Checker for the startup sequencer, bound to its top module.
// Assumes a master that holds each APB request until ready is sampled.
`timescale 1ns/1ps
`default_nettype none
module pcs_startup_monitor (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [2:0] MODE_PIN_IN,
  input wire logic COMPLETION_PIN_OUT,
  input wire logic COMPLETION_PIN_OE_N_OUT,
  input wire logic GLOBAL_WRITE_ENABLE_OUT,
  input wire logic BLOCK_MEMORY_ACCESS_OUT,
  input wire logic GLOBAL_IO_THREE_STATE_OUT,
  input wire logic IO_THREE_STATE_RELEASE_OUT,
  input wire logic PERSIST_SERIAL_PINS_OUT,
  input wire logic PERSIST_PARALLEL_PINS_OUT,
  input wire logic READBACK_BLOCK_OUT,
  input wire logic RECONFIG_BLOCK_OUT
);
  default clocking dcb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Output pairs and sticky startup outputs.
  chk_mem_gated: assert property (BLOCK_MEMORY_ACCESS_OUT == GLOBAL_WRITE_ENABLE_OUT)
    else $error("memory access differs from write enable");
  chk_ts_pair: assert property (IO_THREE_STATE_RELEASE_OUT != GLOBAL_IO_THREE_STATE_OUT)
    else $error("release is not the inverse of three-state");
  chk_we_sticky: assert property (GLOBAL_WRITE_ENABLE_OUT |=> GLOBAL_WRITE_ENABLE_OUT)
    else $error("write enable fell after rising");
  chk_ts_sticky: assert property (!GLOBAL_IO_THREE_STATE_OUT |=> !GLOBAL_IO_THREE_STATE_OUT)
    else $error("three-state returned after release");
  chk_done_sticky: assert property ((COMPLETION_PIN_OE_N_OUT || COMPLETION_PIN_OUT)
    |=> (COMPLETION_PIN_OE_N_OUT || COMPLETION_PIN_OUT)) else $error("completion went back low");
  chk_sec_nested: assert property (RECONFIG_BLOCK_OUT |-> READBACK_BLOCK_OUT)
    else $error("reconfiguration blocked without readback blocked");
  chk_persist_mode: assert property (PERSIST_PARALLEL_PINS_OUT |->
    ($past(MODE_PIN_IN) == 3'h6 && !PERSIST_SERIAL_PINS_OUT)) else $error("wrong persisted set");
  // Register bus answers after exactly one wait cycle and for one cycle only.
  chk_ready_wait: assert property ((PSEL_IN && PENABLE_IN && !PREADY_OUT) |=> PREADY_OUT)
    else $error("ready missing one cycle into access");
  chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  chk_data_idle: assert property (!PREADY_OUT |-> (PRDATA_OUT == 32'h0 && !PSLVERR_OUT))
    else $error("read data or error outside answer");
  // Main scenarios.
  cov_we: cover property ($rose(GLOBAL_WRITE_ENABLE_OUT));
  cov_done: cover property ($rose(COMPLETION_PIN_OE_N_OUT));
  cov_err: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule // pcs_startup_monitor
bind pcs_startup pcs_startup_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .MODE_PIN_IN(MODE_PIN_IN),
  .COMPLETION_PIN_OUT(COMPLETION_PIN_OUT), .COMPLETION_PIN_OE_N_OUT(COMPLETION_PIN_OE_N_OUT),
  .GLOBAL_WRITE_ENABLE_OUT(GLOBAL_WRITE_ENABLE_OUT),
  .BLOCK_MEMORY_ACCESS_OUT(BLOCK_MEMORY_ACCESS_OUT),
  .GLOBAL_IO_THREE_STATE_OUT(GLOBAL_IO_THREE_STATE_OUT),
  .IO_THREE_STATE_RELEASE_OUT(IO_THREE_STATE_RELEASE_OUT),
  .PERSIST_SERIAL_PINS_OUT(PERSIST_SERIAL_PINS_OUT),
  .PERSIST_PARALLEL_PINS_OUT(PERSIST_PARALLEL_PINS_OUT),
  .READBACK_BLOCK_OUT(READBACK_BLOCK_OUT), .RECONFIG_BLOCK_OUT(RECONFIG_BLOCK_OUT));
`default_nettype wire

// ### sim/pcs_chain_model.sv
// Host and chained-device model: startup clock pulses and shared completion wire.
// Assumes step requests are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pcs_chain_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic hold_low_in,
  input wire logic pin_in,
  input wire logic pin_oe_n_in,
  output logic sclk_out,
  output logic level_out
);
  logic [1:0] cnt_reg;
  // One startup clock pulse of three cycles per request; it stands still otherwise.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 2'h0;
    end else if (step_in) begin
      cnt_reg <= 2'h3;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
  assign sclk_out = (cnt_reg != 2'h0);
  // The wire has a pull-up; a low driver or a chained device holding low wins.
  assign level_out = !((!pin_oe_n_in && !pin_in) || hold_low_in);
endmodule // pcs_chain_model
`default_nettype wire

// ### sim/pcs_startup_tb_top.sv
// Self-checking bench for the startup sequencer with its register bus.
// Assumes the chain model and the bound checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module pcs_startup_tb_top;
  logic clk_in = 1'h0, rst_n_in = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic stp = 1'h0, hold = 1'h0, lock = 1'h0, imp = 1'h0, ld = 1'h0, rerr, sclk, lvl;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, code = 32'h0, rdat;
  logic [2:0] mode = 3'h0;
  logic [1:0] csel = 2'h0;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  wire [31:0] prd;
  wire rdy, err, cpo, coe, we, mem, ts, rel, pser, ppar, rb, rc;
  // System clock of 100 ns.
  always #50 clk_in = ~clk_in;
  pcs_chain_model u_chain (.clk_in(clk_in), .rst_n_in(rst_n_in), .step_in(stp),
    .hold_low_in(hold), .pin_in(cpo), .pin_oe_n_in(coe), .sclk_out(sclk), .level_out(lvl));
  pcs_startup dut (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .CONFIGURATION_CLOCK_IN(sclk && csel == 2'h0),
    .USER_CLOCK_IN(sclk && csel == 2'h1), .TEST_CLOCK_IN(sclk && csel == 2'h2),
    .CODE_LOAD_IN(ld), .CODE_DATA_IN(code), .CLOCK_MANAGER_LOCK_IN(lock),
    .IMPEDANCE_CONTROLLER_LOCK_IN(imp), .MODE_PIN_IN(mode), .COMPLETION_PIN_IN(lvl),
    .COMPLETION_PIN_OUT(cpo), .COMPLETION_PIN_OE_N_OUT(coe), .GLOBAL_WRITE_ENABLE_OUT(we),
    .BLOCK_MEMORY_ACCESS_OUT(mem), .GLOBAL_IO_THREE_STATE_OUT(ts),
    .IO_THREE_STATE_RELEASE_OUT(rel), .PERSIST_SERIAL_PINS_OUT(pser),
    .PERSIST_PARALLEL_PINS_OUT(ppar), .READBACK_BLOCK_OUT(rb), .RECONFIG_BLOCK_OUT(rc));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; data and error are taken at the rising edge that samples ready.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'h1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'h1;
    do begin
      @(posedge clk_in);
    end while (rdy !== 1'h1);
    chk(rdy, 1'h1);
    rdat = prd;
    rerr = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Requests k startup clock pulses and lets the outputs settle.
  task automatic step(input int k);
    repeat (k) begin
      @(posedge clk_in);
      stp <= 1'h1;
      @(posedge clk_in);
      stp <= 1'h0;
      repeat (6) @(posedge clk_in);
    end
    @(negedge clk_in);
  endtask
  // Synchronous reset held for three cycles.
  task automatic rst();
    @(posedge clk_in);
    rst_n_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'h1;
  endtask
  task automatic t_regs();
    rst();
    apb(8'h00, 1'h0, 32'h0);
    chk(rdat, 32'h00007F2E);
    apb(8'h0C, 1'h0, 32'h0);
    chk(rdat, 32'hFFFFFFFF);
    apb(8'h0C, 1'h1, 32'h0);
    chk(rerr, 1'h1);
    apb(8'h10, 1'h0, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(8'h00, 1'h1, 32'h00047F2E);
    apb(8'h00, 1'h0, 32'h0);
    chk(rdat, 32'h00047F2E);
    chk({rb, rc, we, ts, coe}, 32'h12);
    @(posedge clk_in);
    ld <= 1'h1;
    code <= 32'h5A3C96E1;
    @(posedge clk_in);
    ld <= 1'h0;
    apb(8'h0C, 1'h0, 32'h0);
    chk(rdat, 32'h5A3C96E1);
    $display("test registers done");
  endtask
  task automatic t_default();
    rst();
    apb(8'h04, 1'h1, 32'h1);
    step(3);
    chk({coe, ts, we, pser}, 32'h5);
    step(1);
    chk({coe, ts, we}, 32'h6);
    step(1);
    chk({ts, rel, we}, 32'h2);
    step(1);
    chk({we, mem, pser}, 32'h7);
    step(2);
    apb(8'h08, 1'h0, 32'h0);
    chk({rdat[4], pser, we, coe}, 32'hB);
    $display("test default sequence done");
  endtask
  task automatic t_stall();
    rst();
    apb(8'h00, 1'h1, 32'h000023B9);
    apb(8'h04, 1'h1, 32'h1);
    step(1);
    chk(we, 1'h1);
    step(2);
    apb(8'h08, 1'h0, 32'h0);
    chk(rdat[2:0], 3'h1);
    @(posedge clk_in);
    lock <= 1'h1;
    step(3);
    apb(8'h08, 1'h0, 32'h0);
    chk(rdat[2:0], 3'h2);
    @(posedge clk_in);
    imp <= 1'h1;
    step(6);
    apb(8'h08, 1'h0, 32'h0);
    chk({rdat[4], ts, coe}, 32'h7);
    $display("test stalls done");
  endtask
  task automatic t_follow();
    @(posedge clk_in);
    mode <= 3'h6;
    csel <= 2'h1;
    hold <= 1'h1;
    rst();
    apb(8'h00, 1'h1, 32'h001B7E80);
    repeat (2) @(negedge clk_in);
    chk({rb, rc, ppar, pser}, 32'hE);
    apb(8'h04, 1'h1, 32'h1);
    step(2);
    chk({cpo, coe, we, ts}, 32'h9);
    @(posedge clk_in);
    hold <= 1'h0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk({we, ts}, 32'h2);
    step(6);
    chk({ppar, pser, cpo}, 32'h5);
    $display("test follow completion done");
  endtask
  // Pipelined completion on the test clock: the level counts only after a startup edge.
  task automatic t_pipe();
    @(posedge clk_in);
    csel <= 2'h2;
    hold <= 1'h1;
    rst();
    apb(8'h00, 1'h1, 32'h0020FE78);
    apb(8'h04, 1'h1, 32'h1);
    step(2);
    apb(8'h08, 1'h0, 32'h0);
    chk({rdat[7], rdat[5], rdat[2:0]}, 32'h11);
    @(posedge clk_in);
    hold <= 1'h0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    chk({we, coe, cpo}, 32'h2);
    step(1);
    apb(8'h08, 1'h0, 32'h0);
    chk({rdat[8], rdat[5], rdat[2:0]}, 32'h19);
    step(1);
    apb(8'h08, 1'h0, 32'h0);
    chk(rdat[2:0], 3'h2);
    $display("test pipelined completion done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_in);
    t_regs();
    t_default();
    t_stall();
    t_follow();
    t_pipe();
    end_of_test();
  end
endmodule // pcs_startup_tb_top
`default_nettype wire
